/* File: rtl/spgm_pad_mux.sv */
`timescale 1ns/1ps
module spgm_pad_mux
  import spgm_pkg::*;
(
  spgm_sel_if.mux                  sel,          // Per-pad function
  input  wire logic [NUM_PADS-1:0] pad_in_i,     // Pad input levels
  input  wire logic [NUM_PADS-1:0] card_out_i,   // Card port drive
  input  wire logic [NUM_PADS-1:0] card_oe_i,    // Card port enable
  input  wire logic [NUM_PADS-1:0] alt_out_i,    // Serial port drive
  input  wire logic [NUM_PADS-1:0] alt_oe_i,     // Serial port enable
  input  wire logic [NUM_PADS-1:0] gpio_out_i,   // GPIO drive
  input  wire logic [NUM_PADS-1:0] gpio_oe_i,    // GPIO enable
  output logic      [NUM_PADS-1:0] pad_out_o,    // Selected drive
  output logic      [NUM_PADS-1:0] pad_oe_o,     // Selected enable
  output logic      [NUM_PADS-1:0] card_in_o,    // Pad level to card port
  output logic      [NUM_PADS-1:0] alt_in_o,     // Pad level to serial port
  output logic      [NUM_PADS-1:0] gpio_in_o     // Pad level to GPIO
);

  genvar i;
  generate
    for (i = 0; i < NUM_PADS; i++)
    begin : g_pad
      wire logic is_card = (sel.func[i] == FN_CARD);
      wire logic is_alt  = (sel.func[i] == FN_ALT);
      wire logic is_gpio = (sel.func[i] == FN_GPIO);
      // Deselected functions see a low input so they never act on a foreign pad
      assign pad_out_o[i] = (is_card & card_out_i[i]) | (is_alt & alt_out_i[i])
                          | (is_gpio & gpio_out_i[i]);
      assign pad_oe_o[i]  = (is_card & card_oe_i[i]) | (is_alt & alt_oe_i[i])
                          | (is_gpio & gpio_oe_i[i]);
      assign card_in_o[i] = is_card & pad_in_i[i];
      assign alt_in_o[i]  = is_alt & pad_in_i[i];
      assign gpio_in_o[i] = is_gpio & pad_in_i[i];
    end
  endgenerate

endmodule

/* File: rtl/spgm_pkg.sv */
package spgm_pkg;

  // Pads covered by this block and the general-purpose line on the first one
  localparam int NUM_PADS    = 7;
  localparam int GPIO_FIRST  = 4;
  localparam int GPIO_LAST   = 10;
  localparam int SP0_PADS    = 2;

  // Register indices; byte address is four times the index
  localparam logic [15:0] BUS_SEL_IDX   = 16'h1C00;
  localparam logic [15:0] PAD_STATE_IDX = 16'h1C01;
  localparam logic [15:0] PUD_INH1_IDX  = 16'h1C17;

  // Field layout of the bus selection register
  localparam int SP0_MODE_LSB = 0;
  localparam int SP1_MODE_LSB = 2;
  localparam int MODE_W       = 2;

  // Mode encodings; code zero is the first-listed function
  localparam logic [1:0] MODE_CARD = 2'h0;
  localparam logic [1:0] MODE_ALT  = 2'h1;
  localparam logic [1:0] MODE_GPIO = 2'h2;

  // Reset values and the bus selection write mask
  localparam logic [15:0] BUS_SEL_RESET  = 16'h0000;
  localparam logic [15:0] PUD_INH1_RESET = 16'h07F0;
  localparam logic [15:0] BUS_SEL_MASK   = 16'h000F;

  // Pad state layout
  localparam int PST_IN_LSB = 0;
  localparam int PST_OE_LSB = 8;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    FN_CARD = 3'h1,
    FN_ALT  = 3'h2,
    FN_GPIO = 3'h4
  } spgm_func_t;

  // Mode field to pad function; the spare code falls back to GPIO
  function automatic spgm_func_t spgm_mode_func(input logic [1:0] mode);
    spgm_func_t f;
    f = FN_GPIO;
    unique case (mode)
      MODE_CARD: f = FN_CARD;
      MODE_ALT:  f = FN_ALT;
      default:   f = FN_GPIO;
    endcase
    return f;
  endfunction

endpackage

/* File: rtl/spgm_sel_if.sv */
`timescale 1ns/1ps
interface spgm_sel_if;
  import spgm_pkg::*;
  spgm_func_t func [NUM_PADS];
  modport ctrl (output func);
  modport mux  (input  func);
endinterface

/* File: rtl/spgm_top.sv */
`timescale 1ns/1ps
module spgm_top
  import spgm_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic                    clock_i,        // 50 MHz clock
  input  wire logic                    resetn_i,       // Async reset, low
  input  wire logic                    ce_i,           // Clock enable
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,   // Write address
  input  wire logic                    s_axi_awvalid,  // Write address valid
  output logic                         s_axi_awready,  // Write address ready
  input  wire logic [31:0]             s_axi_wdata,    // Write data
  input  wire logic [3:0]              s_axi_wstrb,    // Write strobes
  input  wire logic                    s_axi_wvalid,   // Write data valid
  output logic                         s_axi_wready,   // Write data ready
  output logic [1:0]                   s_axi_bresp,    // Write response
  output logic                         s_axi_bvalid,   // Write response valid
  input  wire logic                    s_axi_bready,   // Write response ready
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,   // Read address
  input  wire logic                    s_axi_arvalid,  // Read address valid
  output logic                         s_axi_arready,  // Read address ready
  output logic [31:0]                  s_axi_rdata,    // Read data
  output logic [1:0]                   s_axi_rresp,    // Read response
  output logic                         s_axi_rvalid,   // Read data valid
  input  wire logic                    s_axi_rready,   // Read data ready
  input  wire logic [spgm_pkg::NUM_PADS-1:0] pad_in_i,      // Pad levels
  output logic [spgm_pkg::NUM_PADS-1:0]      pad_out_o,     // Pad drive
  output logic [spgm_pkg::NUM_PADS-1:0]      pad_oe_o,      // Pad enable
  output logic [spgm_pkg::NUM_PADS-1:0]      pulldown_en_o, // Pulldown on
  input  wire logic [spgm_pkg::NUM_PADS-1:0] card_out_i,    // Card drive
  input  wire logic [spgm_pkg::NUM_PADS-1:0] card_oe_i,     // Card enable
  output logic [spgm_pkg::NUM_PADS-1:0]      card_in_o,     // Card input
  input  wire logic [spgm_pkg::NUM_PADS-1:0] alt_out_i,     // Serial/SPI drive
  input  wire logic [spgm_pkg::NUM_PADS-1:0] alt_oe_i,      // Serial/SPI enable
  output logic [spgm_pkg::NUM_PADS-1:0]      alt_in_o,      // Serial/SPI input
  input  wire logic [spgm_pkg::GPIO_LAST:spgm_pkg::GPIO_FIRST] gpio_out_i, // GPIO drive
  input  wire logic [spgm_pkg::GPIO_LAST:spgm_pkg::GPIO_FIRST] gpio_oe_i,  // GPIO enable
  output logic [spgm_pkg::GPIO_LAST:spgm_pkg::GPIO_FIRST]      gpio_in_o   // GPIO input
);
  import spgm_pkg::*;

  // The byte address of the highest index needs fifteen bits
  generate
    if (ADDR_W < 15 || ADDR_W > 32)
    begin : g_bad_addr
      $error("spgm_top: ADDR_W must be 15 to 32");
    end
  endgenerate

  localparam int IDX_W = ADDR_W - 2;

  logic [15:0]         bus_selection_register;
  logic [15:0]         pulldown_inhibit_group1;
  logic [ADDR_W-1:0]   wr_addr;
  logic [31:0]         wr_data;
  logic [3:0]          wr_strb;

  spgm_sel_if sel_bus ();

  wire logic [NUM_PADS-1:0] mux_out;
  wire logic [NUM_PADS-1:0] mux_oe;
  wire logic [NUM_PADS-1:0] mux_card_in;
  wire logic [NUM_PADS-1:0] mux_alt_in;
  wire logic [NUM_PADS-1:0] mux_gpio_in;

  wire logic [MODE_W-1:0] serial_port0_mode_field =
    bus_selection_register[SP0_MODE_LSB +: MODE_W];
  wire logic [MODE_W-1:0] serial_port1_mode_field =
    bus_selection_register[SP1_MODE_LSB +: MODE_W];

  genvar p;
  generate
    for (p = 0; p < NUM_PADS; p++)
    begin : g_sel
      if (p < SP0_PADS)
      begin : g_sp0
        assign sel_bus.func[p] = spgm_mode_func(serial_port0_mode_field);
      end
      else
      begin : g_sp1
        assign sel_bus.func[p] = spgm_mode_func(serial_port1_mode_field);
      end
    end
  endgenerate

  spgm_pad_mux u_mux (
    .sel        (sel_bus.mux),
    .pad_in_i   (pad_in_i),
    .card_out_i (card_out_i),
    .card_oe_i  (card_oe_i),
    .alt_out_i  (alt_out_i),
    .alt_oe_i   (alt_oe_i),
    .gpio_out_i (gpio_out_i),
    .gpio_oe_i  (gpio_oe_i),
    .pad_out_o  (mux_out),
    .pad_oe_o   (mux_oe),
    .card_in_o  (mux_card_in),
    .alt_in_o   (mux_alt_in),
    .gpio_in_o  (mux_gpio_in)
  );

  // Address decode
  wire logic [IDX_W-1:0] wr_idx = wr_addr[ADDR_W-1:2];
  wire logic [IDX_W-1:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire logic wr_sel_bus  = (wr_idx == IDX_W'(BUS_SEL_IDX));
  wire logic wr_sel_pud  = (wr_idx == IDX_W'(PUD_INH1_IDX));
  wire logic wr_sel_pst  = (wr_idx == IDX_W'(PAD_STATE_IDX));
  wire logic rd_sel_bus  = (rd_idx == IDX_W'(BUS_SEL_IDX));
  wire logic rd_sel_pud  = (rd_idx == IDX_W'(PUD_INH1_IDX));
  wire logic rd_sel_pst  = (rd_idx == IDX_W'(PAD_STATE_IDX));
  wire logic wr_mapped   = wr_sel_bus | wr_sel_pud | wr_sel_pst;
  wire logic rd_mapped   = rd_sel_bus | rd_sel_pud | rd_sel_pst;

  // Both halves held and no response pending: commit now
  wire logic wr_commit   = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire logic aw_take     = s_axi_awvalid & s_axi_awready;
  wire logic w_take      = s_axi_wvalid & s_axi_wready;
  wire logic b_done      = s_axi_bvalid & s_axi_bready;
  wire logic ar_take     = s_axi_arvalid & s_axi_arready;
  wire logic r_done      = s_axi_rvalid & s_axi_rready;

  // Byte-lane merge for the two 16-bit registers
  wire logic [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire logic [15:0] next_bus_sel =
    ((bus_selection_register & ~lane_mask) | (wr_data[15:0] & lane_mask)) & BUS_SEL_MASK;
  wire logic [15:0] next_pud_inh =
    (pulldown_inhibit_group1 & ~lane_mask) | (wr_data[15:0] & lane_mask);

  // Pad state is read-only: drive enables and levels as they stand
  wire logic [15:0] pad_state =
    16'(pad_oe_o) << PST_OE_LSB | 16'(pad_in_i) << PST_IN_LSB;

  wire logic [15:0] rd_value =
    rd_sel_bus ? bus_selection_register :
    rd_sel_pud ? pulldown_inhibit_group1 :
    rd_sel_pst ? pad_state : 16'h0000;

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      wr_addr       <= '0;
      wr_data       <= 32'h0000_0000;
      wr_strb       <= 4'h0;
    end
    else if (ce_i)
    begin
      if (aw_take)
      begin
        wr_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take)
      begin
        wr_data      <= s_axi_wdata;
        wr_strb      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_commit)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_mapped && !wr_sel_pst) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_done)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bus_selection_register  <= BUS_SEL_RESET;
      pulldown_inhibit_group1 <= PUD_INH1_RESET;
    end
    else if (ce_i && wr_commit)
    begin
      if (wr_sel_bus)
        bus_selection_register <= next_bus_sel;
      if (wr_sel_pud)
        pulldown_inhibit_group1 <= next_pud_inh;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (ar_take)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_value};
        s_axi_rresp   <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (r_done)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Registered pad side; one cycle from mode change to pad
  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pad_out_o     <= '0;
      pad_oe_o      <= '0;
      pulldown_en_o <= '0;
      card_in_o     <= '0;
      alt_in_o      <= '0;
      gpio_in_o     <= '0;
    end
    else if (ce_i)
    begin
      pad_out_o     <= mux_out;
      pad_oe_o      <= mux_oe;
      pulldown_en_o <= ~pulldown_inhibit_group1[GPIO_LAST:GPIO_FIRST];
      card_in_o     <= mux_card_in;
      alt_in_o      <= mux_alt_in;
      gpio_in_o     <= mux_gpio_in;
    end
  end

endmodule

/* File: sim/serial_port_gpio_pin_mux_test.sv */
`timescale 1ns/1ps
module serial_port_gpio_pin_mux_test;
  import spgm_pkg::*;
  localparam logic [15:0] SEL_A = 16'(BUS_SEL_IDX << 2);
  localparam logic [15:0] PST_A = 16'(PAD_STATE_IDX << 2);
  localparam logic [15:0] INH_A = 16'(PUD_INH1_IDX << 2);
  localparam logic [15:0] BAD_A = 16'h7008;
  logic        clock_i = 1'h0, resetn_i = 1'h0, ce_i = 1'h1;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, seed = 32'h0000_0016;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  pad_in_i = 7'h0, card_out_i = 7'h0, card_oe_i = 7'h0;
  logic [6:0]  alt_out_i = 7'h0, alt_oe_i = 7'h0;
  logic [6:0]  pad_out_o, pad_oe_o, pulldown_en_o, card_in_o, alt_in_o;
  logic [10:4] gpio_out_i = 7'h0, gpio_oe_i = 7'h0, gpio_in_o;
  int          err_count = 0, total_checks = 0;

  spgm_top dut (.*);

  always #10 clock_i = ~clock_i;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Each transfer waits an edge first so no signal is driven twice in one step
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    // No fixed latency assumed; only the watchdog ends a hung wait
    do
    begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  task automatic drive();
    logic [63:0] r;
    r = {rnd(), rnd()};
    pad_in_i <= r[6:0];
    card_out_i <= r[13:7];
    card_oe_i <= r[20:14];
    alt_out_i <= r[27:21];
    alt_oe_i <= r[34:28];
    gpio_out_i <= r[41:35];
    gpio_oe_i <= r[48:42];
  endtask

  // Reference mux: pads 0..1 follow the low mode field, the rest the high one
  task automatic pads(input logic [3:0] m, output logic [6:0] ee);
    logic [6:0] eo, ec, ea, eg;
    logic [1:0] s;
    for (int i = 0; i < NUM_PADS; i++)
    begin
      s = (i < SP0_PADS) ? m[1:0] : m[3:2];
      eo[i] = s == MODE_CARD ? card_out_i[i] : s == MODE_ALT ? alt_out_i[i] : gpio_out_i[i+4];
      ee[i] = s == MODE_CARD ? card_oe_i[i] : s == MODE_ALT ? alt_oe_i[i] : gpio_oe_i[i+4];
      ec[i] = s == MODE_CARD && pad_in_i[i];
      ea[i] = s == MODE_ALT && pad_in_i[i];
      eg[i] = s[1] && pad_in_i[i];
    end
    chk(32'(pad_out_o), 32'(eo));
    chk(32'(pad_oe_o), 32'(ee));
    chk(32'(card_in_o), 32'(ec));
    chk(32'(alt_in_o), 32'(ea));
    chk(32'(gpio_in_o), 32'(eg));
  endtask

  task automatic rst();
    resetn_i <= 1'h0;
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'h1;
    @(posedge clock_i);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    logic [6:0]  oe;
    logic [15:0] v;
    rst();
    drive();
    repeat (3) @(posedge clock_i);
    pads(4'h0, oe);
    chk(32'(pulldown_en_o), 32'h0);
    rd(SEL_A, 32'h0, RESP_OKAY);
    rd(INH_A, 32'h0000_07F0, RESP_OKAY);
    for (int m = 0; m < 16; m++)
    begin
      wr(SEL_A, 32'(m), RESP_OKAY);
      drive();
      repeat (3) @(posedge clock_i);
      pads(4'(m), oe);
      rd(PST_A, {17'h0, oe, 1'h0, pad_in_i}, RESP_OKAY);
      rd(SEL_A, 32'(m), RESP_OKAY);
    end
    // Clock enable low must hold the pad enables at their last value
    ce_i <= 1'h0;
    drive();
    repeat (3) @(posedge clock_i);
    chk(32'(pad_oe_o), 32'(oe));
    ce_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    pads(4'hF, oe);
    wr(SEL_A, 32'hFFFF_FFF0, RESP_OKAY);
    rd(SEL_A, 32'h0, RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      v = k == 0 ? 16'hFFFF : k == 1 ? 16'h0000 : 16'(rnd());
      wr(INH_A, 32'(v), RESP_OKAY);
      rd(INH_A, 32'(v), RESP_OKAY);
      chk(32'(pulldown_en_o), {25'h0, ~v[10:4]});
    end
    // Only the upper byte lane may land
    s_axi_wstrb <= 4'h2;
    v = {8'h5A, v[7:0]};
    wr(INH_A, 32'h0000_5AA5, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(INH_A, 32'(v), RESP_OKAY);
    chk(32'(pulldown_en_o), {25'h0, ~v[10:4]});
    wr(BAD_A, 32'h0000_FFFF, RESP_SLVERR);
    rd(BAD_A, 32'h0, RESP_SLVERR);
    wr(PST_A, 32'h0000_FFFF, RESP_SLVERR);
    rd(INH_A, 32'(v), RESP_OKAY);
    rst();
    chk(32'(pulldown_en_o), 32'h0);
    rd(INH_A, 32'h0000_07F0, RESP_OKAY);
    end_sim();
  end

  // Whole run is well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock_i);
    err_count++;
    end_sim();
  end
endmodule

bind spgm_top spgm_props u_props (.*);

/* File: sim/spgm_props.sv */
`timescale 1ns/1ps
module spgm_props
(
  input wire logic        clock_i,       // Clock
  input wire logic        resetn_i,      // Reset
  input wire logic        ce_i,          // Enable
  input wire logic        s_axi_awvalid, // AW
  input wire logic        s_axi_awready, // AW
  input wire logic        s_axi_wvalid,  // W
  input wire logic        s_axi_wready,  // W
  input wire logic        s_axi_bvalid,  // B
  input wire logic        s_axi_bready,  // B
  input wire logic        s_axi_arvalid, // AR
  input wire logic        s_axi_arready, // AR
  input wire logic        s_axi_rvalid,  // R
  input wire logic        s_axi_rready,  // R
  input wire logic [31:0] s_axi_rdata,   // R
  input wire logic [6:0]  pad_out_o,     // Pads
  input wire logic [6:0]  pad_oe_o,      // Pads
  input wire logic [6:0]  pulldown_en_o, // Pulls
  input wire logic [6:0]  card_out_i,    // Card
  input wire logic [6:0]  card_oe_i,     // Card
  input wire logic [6:0]  card_in_o,     // Card
  input wire logic [6:0]  alt_in_o,      // Alt
  input wire logic [10:4] gpio_in_o      // GPIO
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  a_card_reset: assert property (
    $rose(resetn_i) && ce_i |=> pad_out_o == $past(card_out_i) && pad_oe_o == $past(card_oe_i))
    else $error("pads not on card port after reset");
  a_pd_reset: assert property (
    $rose(resetn_i) |-> pulldown_en_o == 7'h0 ##1 pulldown_en_o == 7'h0)
    else $error("pulldown on after reset");
  a_one_func: assert property (
    (card_in_o & alt_in_o) == 7'h0 && ((card_in_o | alt_in_o) & gpio_in_o) == 7'h0)
    else $error("pad routed to two functions");
  a_pd_cause: assert property (
    $changed(pulldown_en_o) |-> $past(s_axi_bvalid))
    else $error("pulldown changed without a write");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce_i
    |=> !s_axi_awready ##[0:1] s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready && ce_i |=> !s_axi_arready ##[0:1] s_axi_rvalid)
    else $error("read not answered");
  a_b_hold: assert property (
    s_axi_bvalid && !(s_axi_bready && ce_i) |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !(s_axi_rready && ce_i) |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped or changed");
  a_b_done: assert property (
    s_axi_bvalid && s_axi_bready && ce_i |=> !s_axi_bvalid ##[0:1] s_axi_awready)
    else $error("write channel not freed");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_pull: cover property ($changed(pulldown_en_o));
endmodule
